// File: lvc_map.vh
`ifndef LVC_MAP_VH
`define LVC_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LVC_ADDR_CTRL       8'h00
`define LVC_ADDR_SERIAL     8'h04
`define LVC_ADDR_PHASE      8'h08
`define LVC_ADDR_STATUS     8'h0c
`define LVC_ADDR_COUNTERS   8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define LVC_CTRL_RUN        0
`define LVC_CTRL_USE_LO     1
`define LVC_CTRL_SPLIT      3
`define LVC_SER_WIDTH_LO    0
`define LVC_SER_BAND_LO     4
`define LVC_CTRL_RST        4'h0
`define LVC_SERIAL_RST      7'h04
`define LVC_PHASE_RST       8'h00

// Usage of the loop
`define LVC_USE_TX          2'h1
`define LVC_USE_RX          2'h2
`define LVC_USE_BOTH        2'h3

// Width codes
`define LVC_W_X1            3'h0
`define LVC_W_X2            3'h1
`define LVC_W_X4            3'h2
`define LVC_W_X7            3'h3
`define LVC_W_X8            3'h4
`define LVC_W_X10           3'h5

// Counter limits
`define LVC_M_MAX           8'h20
`define LVC_N_VAL           8'h01

// ****************************************************************
// Timing
// ****************************************************************
`define LVC_SYS_PERIOD_NS   100
`define LVC_REF_LOSS_NS     6400
`define LVC_LOOP_RST_NS     1600
`define LVC_REF_LOSS_CYC    (`LVC_REF_LOSS_NS / `LVC_SYS_PERIOD_NS)
`define LVC_LOOP_RST_CYC    ((`LVC_LOOP_RST_NS + `LVC_SYS_PERIOD_NS - 1) / `LVC_SYS_PERIOD_NS)
`define LVC_LOCK_PERIODS    4
`define LVC_FAST_RATIO      8
`endif

// File: lvc_counter_rom.v
`timescale 1ns/1ps
`include "lvc_map.vh"
module lvc_counter_rom
(
    input  wire       i_clk_sys,     // System clock
    input  wire       i_reset,       // Sync reset, high
    input  wire       i_clk_en,      // Clock enable
    input  wire [2:0] i_width,       // Width code
    input  wire [2:0] i_band,        // Rate band
    output reg  [7:0] o_n,           // Divider
    output reg  [7:0] o_m,           // Multiplier
    output reg  [7:0] o_g_fast,      // Fast post-scaler
    output reg  [7:0] o_g_slow,      // Slow post-scaler
    output reg        o_double_rate_io_register,        // Double-rate cells used
    output reg        o_valid        // Setting exists
);

    function [7:0] width_val;
        input [2:0] code;
        begin
            case (code)
                `LVC_W_X1:  width_val = 8'h01;
                `LVC_W_X2:  width_val = 8'h02;
                `LVC_W_X4:  width_val = 8'h04;
                `LVC_W_X7:  width_val = 8'h07;
                `LVC_W_X8:  width_val = 8'h08;
                `LVC_W_X10: width_val = 8'h0a;
                default:    width_val = 8'h00;
            endcase
        end
    endfunction

    reg [11:0] m_full;
    reg [7:0]  g_val;
    reg        is_x1;

    // Multiplier doubles per band, post-scaler per band
    always @*
    begin
        is_x1 = (i_width == `LVC_W_X1);
        if (is_x1)
            m_full = {4'h0, 8'h02} << i_band;
        else
            m_full = {4'h0, width_val(i_width)} << i_band;
        case (i_band)
            3'h0:    g_val = 8'h02;
            3'h1:    g_val = 8'h04;
            3'h2:    g_val = 8'h04;
            3'h3:    g_val = 8'h08;
            3'h4:    g_val = 8'h10;
            default: g_val = 8'h00;
        endcase
        if (is_x1)
            g_val = m_full[7:0];
    end

    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_n      <= 8'h00;
            o_m      <= 8'h00;
            o_g_fast <= 8'h00;
            o_g_slow <= 8'h00;
            o_double_rate_io_register   <= 1'b0;
            o_valid  <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_n      <= `LVC_N_VAL;
            o_m      <= m_full[7:0];
            o_g_fast <= g_val;
            o_g_slow <= m_full[7:0];
            o_double_rate_io_register   <= !is_x1;
            o_valid  <= (m_full <= {4'h0, `LVC_M_MAX}) && (g_val != 8'h00)
                        && (width_val(i_width) != 8'h00);
        end
    end

endmodule // lvc_counter_rom

// File: lvc_clocking.v
`timescale 1ns/1ps
`include "lvc_map.vh"
module lvc_clocking #(
    parameter PW         = 8,                     // Period counter width
    parameter LOSS_CYC   = `LVC_REF_LOSS_CYC,     // Reference loss timeout
    parameter RST_CYC    = `LVC_LOOP_RST_CYC,     // Loop reset length
    parameter LOCK_PER   = `LVC_LOCK_PERIODS      // Stable periods to lock
)
(
    input  wire        i_clk_sys,      // System clock 10 MHz
    input  wire        i_reset,        // Sync reset, high
    input  wire        i_clk_en,       // Clock enable, freezes state
    input  wire        i_loop_ref,     // Reference clock pin
    input  wire        i_psel,         // APB select
    input  wire        i_penable,      // APB enable
    input  wire        i_pwrite,       // APB direction
    input  wire [7:0]  i_paddr,        // APB address
    input  wire [31:0] i_pwdata,       // APB write data
    output reg         o_pready,       // APB ready
    output reg  [31:0] o_prdata,       // APB read data
    output reg         o_pslverr,      // APB error
    output reg         o_fast_clock,   // Fast clock, 4x reference
    output reg         o_slow_clock,   // Slow clock, 1x reference
    output reg         o_fwd_clk_p,    // Forwarded clock, true
    output reg         o_fwd_clk_n,    // Forwarded clock, complement
    output reg         o_loop_reset,   // Loop reset, high
    output reg         o_locked,       // Lock indicator
    output reg         o_no_comp,      // Uncompensated mode selected
    output reg         o_double_rate_io_register_en,      // Double-rate cells in use
    output reg         o_serdes_en     // Serializer enable
);

    // ****************************************************************
    // Reference synchroniser and edge detect
    // ****************************************************************
    reg          ref_s1_r;
    reg          ref_s2_r;
    reg          ref_s3_r;
    wire         ref_rise = ref_s2_r & ~ref_s3_r;

    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            ref_s1_r <= i_loop_ref;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [3:0]   ctrl_r;
    reg  [6:0]   serial_r;
    reg  [7:0]   phase_r;
    wire [7:0]   cnt_n;
    wire [7:0]   cnt_m;
    wire [7:0]   cnt_gf;
    wire [7:0]   cnt_gs;
    wire         cnt_double_rate_io_register;
    wire         cnt_valid;
    reg  [PW-1:0] period_r;
    reg          lost_r;
    reg  [31:0]  rdata_nxt;
    reg          err_nxt;
    wire [15:0]  period_ext = {{(16-PW){1'b0}}, period_r};

    wire         run      = ctrl_r[`LVC_CTRL_RUN];
    wire [1:0]   usage    = ctrl_r[`LVC_CTRL_USE_LO+1:`LVC_CTRL_USE_LO];
    wire         split    = ctrl_r[`LVC_CTRL_SPLIT];
    wire         split_err = split && (usage == `LVC_USE_BOTH);
    wire         use_ok   = (usage != 2'h0);
    wire         cfg_ok   = cnt_valid && use_ok && !split_err;
    wire         setup    = i_psel && !i_penable;
    wire         wr_ack   = i_psel && i_penable && o_pready && i_pwrite;
    wire         cfg_wr   = wr_ack && ((i_paddr == `LVC_ADDR_CTRL)
                            || (i_paddr == `LVC_ADDR_SERIAL) || (i_paddr == `LVC_ADDR_PHASE));

    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        err_nxt   = 1'b0;
        case (i_paddr)
            `LVC_ADDR_CTRL:     rdata_nxt = {28'h0, ctrl_r};
            `LVC_ADDR_SERIAL:   rdata_nxt = {25'h0, serial_r};
            `LVC_ADDR_PHASE:    rdata_nxt = {24'h0, phase_r};
            `LVC_ADDR_STATUS:   rdata_nxt = {16'h0, period_ext[7:0], 1'b0, lost_r,
                                             split_err, cfg_ok, o_double_rate_io_register_en, o_no_comp,
                                             o_loop_reset, o_locked};
            `LVC_ADDR_COUNTERS: rdata_nxt = {cnt_gs, cnt_gf, cnt_m, cnt_n};
            default:            err_nxt = 1'b1;
        endcase
    end

    // Zero-wait slave: ready in the first access cycle
    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
            ctrl_r    <= `LVC_CTRL_RST;
            serial_r  <= `LVC_SERIAL_RST;
            phase_r   <= `LVC_PHASE_RST;
        end
        else if (i_clk_en)
        begin
            o_pready  <= setup;
            o_pslverr <= setup && err_nxt;
            if (setup && !i_pwrite)
                o_prdata <= rdata_nxt;
            if (wr_ack)
            begin
                case (i_paddr)
                    `LVC_ADDR_CTRL:   ctrl_r   <= i_pwdata[3:0];
                    `LVC_ADDR_SERIAL: serial_r <= i_pwdata[6:0];
                    `LVC_ADDR_PHASE:  phase_r  <= i_pwdata[7:0];
                    default:          ctrl_r   <= ctrl_r;
                endcase
            end
        end
    end

    lvc_counter_rom u_rom (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_width   (serial_r[`LVC_SER_WIDTH_LO+2:`LVC_SER_WIDTH_LO]),
        .i_band    (serial_r[`LVC_SER_BAND_LO+2:`LVC_SER_BAND_LO]),
        .o_n       (cnt_n),
        .o_m       (cnt_m),
        .o_g_fast  (cnt_gf),
        .o_g_slow  (cnt_gs),
        .o_double_rate_io_register    (cnt_double_rate_io_register),
        .o_valid   (cnt_valid)
    );

    // ****************************************************************
    // Loop reset and lock tracking
    // ****************************************************************
    reg  [7:0]    rst_cnt_r;
    reg  [PW-1:0] pos_r;
    reg  [3:0]    lock_cnt_r;
    wire          loop_rst_nxt = !run || (rst_cnt_r != 8'h00) || !cfg_ok;

    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            rst_cnt_r    <= 8'h00;
            o_loop_reset <= 1'b1;
            pos_r        <= {PW{1'b0}};
            period_r     <= {PW{1'b0}};
            lost_r       <= 1'b1;
            lock_cnt_r   <= 4'h0;
            o_locked     <= 1'b0;
            o_no_comp    <= 1'b0;
            o_double_rate_io_register_en    <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_loop_reset <= loop_rst_nxt;
            o_no_comp    <= (usage != `LVC_USE_TX);
            o_double_rate_io_register_en    <= cnt_double_rate_io_register;
            if (cfg_wr || (ref_rise && lost_r))
                rst_cnt_r <= RST_CYC[7:0];
            else if (rst_cnt_r != 8'h00)
                rst_cnt_r <= rst_cnt_r - 8'h01;
            if (ref_rise)
            begin
                pos_r    <= {PW{1'b0}};
                period_r <= pos_r + 1'b1;
                lost_r   <= 1'b0;
            end
            else if (pos_r == LOSS_CYC[PW-1:0])
                lost_r   <= 1'b1;
            else
                pos_r    <= pos_r + 1'b1;
            if (loop_rst_nxt || lost_r || (!ref_rise && pos_r == LOSS_CYC[PW-1:0]))
            begin
                lock_cnt_r <= 4'h0;
                o_locked   <= 1'b0;
            end
            else if (ref_rise)
            begin
                if ((pos_r + 1'b1) == period_r && period_r >= `LVC_FAST_RATIO)
                begin
                    if (lock_cnt_r == LOCK_PER[3:0])
                        o_locked   <= 1'b1;
                    else
                        lock_cnt_r <= lock_cnt_r + 4'h1;
                end
                else
                begin
                    lock_cnt_r <= 4'h0;
                    o_locked   <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Fast and slow clock generation
    // ****************************************************************
    reg  [PW-1:0] slice_r;
    reg  [2:0]    half_r;
    reg           fast_nxt;
    wire [PW-1:0] half_len = (period_r < `LVC_FAST_RATIO) ? {{(PW-1){1'b0}}, 1'b1}
                             : (period_r >> 3);
    // Offset may land on the reference edge itself
    wire          align    = (pos_r == phase_r[PW-1:0]);
    wire          run_clk  = o_locked || (lock_cnt_r != 4'h0);

    always @*
    begin
        fast_nxt = o_fast_clock;
        if (align)
            fast_nxt = 1'b1;
        else if (slice_r == half_len - 1'b1)
            fast_nxt = ~o_fast_clock;
    end

    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            slice_r      <= {PW{1'b0}};
            half_r       <= 3'h0;
            o_fast_clock <= 1'b0;
            o_slow_clock <= 1'b0;
            o_fwd_clk_p  <= 1'b0;
            o_fwd_clk_n  <= 1'b1;
            o_serdes_en  <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_serdes_en <= o_locked && !o_loop_reset && cfg_ok;
            if (!run_clk)
            begin
                slice_r      <= {PW{1'b0}};
                half_r       <= 3'h0;
                o_fast_clock <= 1'b0;
                o_slow_clock <= 1'b0;
                o_fwd_clk_p  <= 1'b0;
                o_fwd_clk_n  <= 1'b1;
            end
            else if (align)
            begin
                // Restart both clocks on one shared phase point
                slice_r      <= {PW{1'b0}};
                half_r       <= 3'h0;
                o_fast_clock <= 1'b1;
                o_slow_clock <= 1'b1;
                o_fwd_clk_p  <= 1'b1;
                o_fwd_clk_n  <= 1'b0;
            end
            else
            begin
                if (slice_r == half_len - 1'b1)
                begin
                    slice_r      <= {PW{1'b0}};
                    half_r       <= half_r + 3'h1;
                    o_fast_clock <= fast_nxt;
                    if (half_r == 3'h3 || half_r == 3'h7)
                        o_slow_clock <= ~o_slow_clock;
                end
                else
                    slice_r <= slice_r + 1'b1;
                // Double-rate cell: high half drives one, low half drives zero
                o_fwd_clk_p <= fast_nxt ? 1'b1 : 1'b0;
                o_fwd_clk_n <= fast_nxt ? 1'b0 : 1'b1;
            end
        end
    end

endmodule // lvc_clocking

// File: lvc_ref_model.sv
`timescale 1ns/1ps
module lvc_ref_model #(
    parameter HALF_NS = 400     // Half period of the reference
)
(
    input  logic i_run,         // Source running
    output logic o_ref          // Reference clock pin
);
    // Free-running source, offset from the system clock; parks low when lost
    initial
    begin
        o_ref = 1'b0;
        #137;
        forever
        begin
            #(HALF_NS);
            o_ref = i_run ? !o_ref : 1'b0;
        end
    end
endmodule // lvc_ref_model

// File: lvc_clocking_asserts.sv
`timescale 1ns/1ps
`include "lvc_map.vh"
module lvc_clocking_asserts
(
    input logic        i_clk_sys,     // System clock
    input logic        i_reset,       // Sync reset
    input logic        i_clk_en,      // Clock enable
    input logic        i_psel,        // APB select
    input logic        i_penable,     // APB enable
    input logic        i_pwrite,      // APB direction
    input logic [7:0]  i_paddr,       // APB address
    input logic [31:0] i_pwdata,      // APB write data
    input logic        o_pready,      // APB ready
    input logic        o_pslverr,     // APB error
    input logic        o_fast_clock,  // Fast clock
    input logic        o_slow_clock,  // Slow clock
    input logic        o_fwd_clk_p,   // Forwarded clock
    input logic        o_fwd_clk_n,   // Forwarded clock, inverse
    input logic        o_loop_reset,  // Loop reset
    input logic        o_locked,      // Lock
    input logic        o_no_comp,     // Uncompensated mode
    input logic        o_double_rate_io_register_en,     // Double-rate cells
    input logic        o_serdes_en    // Serializer enable
);
    logic [1:0] use_r;
    logic [2:0] wid_r;
    logic       wr_ok;
    logic       quiet;
    logic       hold;
    assign wr_ok = i_psel && i_penable && i_pwrite && o_pready && i_clk_en;
    assign hold  = i_reset || o_loop_reset || !o_locked || !i_clk_en;
    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            use_r <= 2'h0;
            wid_r <= 3'h4;
        end
        else if (wr_ok && i_paddr == `LVC_ADDR_CTRL)
            use_r <= i_pwdata[2:1];
        else if (wr_ok && i_paddr == `LVC_ADDR_SERIAL)
            wid_r <= i_pwdata[2:0];
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_fwd_compl: assert property (o_fwd_clk_n == !o_fwd_clk_p)
        else $error("forwarded pair not complementary");
    a_fwd_follow: assert property ($rose(o_fast_clock) |-> ##[0:1] $rose(o_fwd_clk_p))
        else $error("forwarded clock not following fast clock");
    a_fast_four: assert property (disable iff (hold)
        $rose(o_slow_clock) |-> o_fast_clock ##1 !o_fast_clock ##1 o_fast_clock
        ##1 !o_fast_clock ##1 o_fast_clock ##1 !o_fast_clock ##1 o_fast_clock ##1 !o_fast_clock)
        else $error("fast clock not four times slow clock");
    a_slow_rate: assert property (disable iff (hold)
        $rose(o_slow_clock) |-> o_slow_clock[*4] ##1 !o_slow_clock[*4] ##1 o_slow_clock)
        else $error("slow clock period wrong");
    a_serdes_lock: assert property (o_serdes_en |-> $past(o_locked) && !$past(o_loop_reset))
        else $error("serializer enabled without lock");
    a_lock_rst: assert property (o_loop_reset && $past(o_loop_reset) |-> !o_locked)
        else $error("lock shown while loop in reset");
    assign quiet = !o_loop_reset;
    a_comp_mode: assert property (quiet && !$past(wr_ok) && !$past(wr_ok, 2)
        |-> o_no_comp == (use_r != `LVC_USE_TX))
        else $error("compensation mode wrong");
    a_double_rate_io_register_mode: assert property (quiet && !$past(wr_ok) && !$past(wr_ok, 2)
        |-> o_double_rate_io_register_en == (wid_r != `LVC_W_X1))
        else $error("double-rate use wrong");
    a_apb_ready: assert property (i_psel && !i_penable && i_clk_en |=> o_pready)
        else $error("no ready in access cycle");
    a_apb_err: assert property (o_pready |-> o_pslverr == !(i_paddr inside
        {`LVC_ADDR_CTRL, `LVC_ADDR_SERIAL, `LVC_ADDR_PHASE, `LVC_ADDR_STATUS, `LVC_ADDR_COUNTERS}))
        else $error("error response wrong");
    c_tx_run: cover property (o_serdes_en && !o_no_comp);
    c_rx_run: cover property (o_serdes_en && o_no_comp);
    c_apb_err: cover property (o_pready && o_pslverr);
endmodule // lvc_clocking_asserts
bind lvc_clocking lvc_clocking_asserts i_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_fast_clock(o_fast_clock), .o_slow_clock(o_slow_clock), .o_fwd_clk_p(o_fwd_clk_p),
    .o_fwd_clk_n(o_fwd_clk_n), .o_loop_reset(o_loop_reset), .o_locked(o_locked),
    .o_no_comp(o_no_comp), .o_double_rate_io_register_en(o_double_rate_io_register_en), .o_serdes_en(o_serdes_en));

// File: lvc_clocking_tb_top.sv
`timescale 1ns/1ps
`include "lvc_map.vh"
module lvc_clocking_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic        rdy, serr, er, fast, slow, fp, fn, lrst, lck, ncmp, double_rate_io_register, sen;
    logic        run = 1'b0;
    logic        cen = 1'b1;
    logic        lref;
    logic [15:0] lfsr = 16'h701f;
    int          miscompares = 0;
    int          n_compared = 0;
    always #50 clk = !clk;
    lvc_ref_model i_ref (.i_run(run), .o_ref(lref));
    lvc_clocking #(.LOSS_CYC(32), .RST_CYC(4), .LOCK_PER(2)) i_dut (.i_clk_sys(clk),
        .i_reset(rst), .i_clk_en(cen), .i_loop_ref(lref), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_pready(rdy), .o_prdata(prd),
        .o_pslverr(serr), .o_fast_clock(fast), .o_slow_clock(slow), .o_fwd_clk_p(fp),
        .o_fwd_clk_n(fn), .o_loop_reset(lrst), .o_locked(lck), .o_no_comp(ncmp),
        .o_double_rate_io_register_en(double_rate_io_register), .o_serdes_en(sen));
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n >= 20)
            miscompares++;
        rd = prd;
        er = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wait_sig(input int lim, output int n);
        n = 0;
        while (sen !== 1'b1 && n < lim)
        begin
            n++;
            @(posedge clk);
        end
    endtask
    // Slow period and fast rises within it
    task automatic measure(output int per, output int fr);
        int t0, t1;
        logic ps, pf;
        t0 = -1;
        t1 = -1;
        fr = 0;
        ps = 1'b1;
        pf = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            if (slow === 1'b1 && ps === 1'b0 && t0 >= 0 && t1 < 0)
                t1 = i;
            if (slow === 1'b1 && ps === 1'b0 && t0 < 0)
                t0 = i;
            if (fast === 1'b1 && pf === 1'b0 && t0 >= 0 && t1 < 0)
                fr++;
            ps = slow;
            pf = fast;
        end
        per = t1 - t0;
    endtask
    // Expected {slow scaler, fast scaler, multiplier, divider}
    function automatic logic [31:0] cnt_exp(input logic [2:0] w, input logic [2:0] b);
        logic [7:0] wv, m, g;
        wv = (w == 3'h0) ? 8'h02 : (w == 3'h1) ? 8'h02 : (w == 3'h2) ? 8'h04 :
             (w == 3'h3) ? 8'h07 : (w == 3'h4) ? 8'h08 : 8'h0a;
        m = wv << b;
        g = (w == `LVC_W_X1) ? m : (b == 3'h0) ? 8'h02 : (b == 3'h1) ? 8'h04 : 8'h04 << (b - 3'h2);
        return {m, g, m, 8'h01};
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic run_cfg(input logic [1:0] u, input logic [2:0] w, input logic [2:0] b);
        logic [31:0] ex;
        int n, per, fr;
        ex = cnt_exp(w, b);
        lfsr = lfsr_next(lfsr);
        apb(1'b1, `LVC_ADDR_SERIAL, {25'h0, b, 1'b0, w});
        apb(1'b1, `LVC_ADDR_PHASE, {29'h0, lfsr[2:0]});
        apb(1'b1, `LVC_ADDR_CTRL, {28'h0, 1'b0, u, 1'b1});
        apb(1'b0, `LVC_ADDR_COUNTERS, 32'h0);
        if (ex[15:8] <= `LVC_M_MAX)
        begin
            chk("counters", ex, rd);
            wait_sig(600, n);
            chk("serdes_en", 1, sen);
            chk("no_comp", {31'h0, u != `LVC_USE_TX}, ncmp);
            chk("double_rate_io_register", {31'h0, w != `LVC_W_X1}, double_rate_io_register);
            measure(per, fr);
            chk("slow period", 8, per);
            chk("fast rises", 4, fr);
        end
        else
        begin
            wait_sig(200, n);
            chk("serdes_en bad cfg", 0, sen);
        end
        $display("config use %0d width %0d band %0d done", u, w, b);
    endtask
    initial
    begin
        int n;
        logic [3:0] snap;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        @(posedge clk);
        chk("loop_reset", 1, lrst);
        chk("locked", 0, lck);
        chk("fwd_n", 1, fn);
        apb(1'b0, `LVC_ADDR_SERIAL, 32'h0);
        chk("serial reset", 32'h4, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 1, er);
        $display("register test done");
        run_cfg(`LVC_USE_RX, `LVC_W_X10, 3'h2);
        run_cfg(`LVC_USE_TX, `LVC_W_X1, 3'h4);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = lfsr_next(lfsr);
            run_cfg(2'(i % 3 + 1), 3'(lfsr[7:4] % 6), 3'(lfsr[11:8] % 5));
        end
        apb(1'b1, `LVC_ADDR_CTRL, 32'hf);
        repeat (4) @(posedge clk);
        wait_sig(200, n);
        apb(1'b0, `LVC_ADDR_STATUS, 32'h0);
        chk("split error", 1, rd[5]);
        chk("serdes split", 0, sen);
        run_cfg(`LVC_USE_BOTH, `LVC_W_X4, 3'h1);
        // Clock enable low freezes every output
        cen <= 1'b0;
        @(posedge clk);
        snap = {fast, slow, lck, sen};
        repeat (10) @(posedge clk);
        chk("frozen", {28'h0, snap}, {28'h0, fast, slow, lck, sen});
        cen <= 1'b1;
        $display("freeze test done");
        run <= 1'b0;
        repeat (60) @(posedge clk);
        chk("locked lost", 0, lck);
        run <= 1'b1;
        n = 0;
        while (lrst !== 1'b1 && n < 40)
        begin
            n++;
            @(posedge clk);
        end
        chk("restart reset", 1, lrst);
        wait_sig(600, n);
        chk("relock", 1, sen);
        $display("loss test done");
        results();
    end
    initial
    begin
        repeat (50000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule // lvc_clocking_tb_top
